// ==== design/kbi_consts.svh ====
// Constants for the keyboard serial interface
// Operation
// - Each key change travels serially as a low start bit, 8 code bits then one stop bit.
// - Seven code bits name the key and the eighth tells pressed or released.
// - The interface answers a request with an acknowledge line.
// - A completed character raises an interrupt to the main processor.
`ifndef KBI_CONSTS_SVH
`define KBI_CONSTS_SVH
`define KBI_CODE_BITS   8
`define KBI_KEY_BITS    7
`define KBI_STATE_BIT   7
`define KBI_NUM_KEYS    8'h68
`define KBI_FIFO_DEPTH  32
`define KBI_BIT_CYCLES  16'h0010
`define KBI_ACK_TMO     16'hFFFF
`endif

// ==== design/kbi_fifo.sv ====
// Parameterised FIFO for received key codes
`timescale 1ns/1ps
`default_nettype none
module kbi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   kbi_stream_if.snk             wr,
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic [WIDTH-1:0]      rd_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      rp_r;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   assign full  = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
   assign empty = (wp_r == rp_r);
   assign wr.ready = !full;
   assign push  = wr.valid && !full;
   // Output register refills whenever empty or being taken
   assign pop   = !empty && (!rd_valid || rd_ready);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= wr.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid <= 1'b0;
         rd_data  <= '0;
      end else if (pop) begin
         rd_valid <= 1'b1;
         rd_data  <= mem[rp_r[AW-1:0]];
      end else if (rd_ready) begin
         rd_valid <= 1'b0;
      end
   end
endmodule : kbi_fifo
`default_nettype wire

// ==== design/kbi_pkg.sv ====
// Types for the keyboard serial interface
package kbi_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_ACK, ST_START, ST_DATA, ST_STOP,
                             ST_PUSH} kbi_state_e;
   typedef logic [7:0] kbi_code_t;
endpackage : kbi_pkg

// ==== design/kbi_stream_if.sv ====
// Valid/ready carrier between receiver and buffer
`timescale 1ns/1ps
`default_nettype none
interface kbi_stream_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : kbi_stream_if
`default_nettype wire

// ==== design/kbi_top.sv ====
// Keyboard serial receiver with acknowledge handshake and code buffer
`include "kbi_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module kbi_top (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       kb_request,
   input  wire logic       kb_data,
   output logic            kb_ack,
   output logic            irq,
   output logic            char_valid,
   input  wire logic       char_ready,
   output logic [7:0]      char_code,
   output logic [6:0]      char_key,
   output logic            char_pressed,
   output logic            overrun
);
   //==========================================================
   // Reset release
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   //==========================================================
   // Receiver
   kbi_pkg::kbi_state_e st_r;
   logic [15:0]         cnt_r;
   logic [3:0]          bit_r;
   kbi_pkg::kbi_code_t  sh_r;
   kbi_stream_if #(.WIDTH(`KBI_CODE_BITS)) rx_s ();
   logic                fifo_valid;
   logic [7:0]          fifo_data;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r  <= kbi_pkg::ST_IDLE;
         cnt_r <= 16'h0000;
         bit_r <= 4'h0;
         sh_r  <= 8'h00;
      end else begin
         unique case (st_r)
            kbi_pkg::ST_IDLE: begin
               cnt_r <= 16'h0000;
               if (kb_request) begin
                  st_r <= kbi_pkg::ST_ACK;
               end
            end
            // Wait for start low; give up if keyboard never sends
            kbi_pkg::ST_ACK: begin
               cnt_r <= cnt_r + 16'h0001;
               if (!kb_data) begin
                  st_r  <= kbi_pkg::ST_START;
                  cnt_r <= 16'h0000;
               end else if (cnt_r == `KBI_ACK_TMO) begin
                  st_r <= kbi_pkg::ST_IDLE;
               end
            end
            // Sample mid-bit, half a bit after start edge
            kbi_pkg::ST_START: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == (`KBI_BIT_CYCLES >> 1)) begin
                  st_r  <= kbi_pkg::ST_DATA;
                  cnt_r <= 16'h0000;
                  bit_r <= 4'h0;
               end
            end
            kbi_pkg::ST_DATA: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == `KBI_BIT_CYCLES - 16'h0001) begin
                  cnt_r <= 16'h0000;
                  sh_r  <= {kb_data, sh_r[7:1]};
                  bit_r <= bit_r + 4'h1;
                  if (bit_r == 4'(`KBI_CODE_BITS - 1)) begin
                     st_r <= kbi_pkg::ST_STOP;
                  end
               end
            end
            // stop bit must be high, else frame dropped
            kbi_pkg::ST_STOP: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == `KBI_BIT_CYCLES - 16'h0001) begin
                  st_r <= kb_data ? kbi_pkg::ST_PUSH : kbi_pkg::ST_IDLE;
               end
            end
            // Stall here while buffer is full; the frame waits in sh_r and no ack is given
            kbi_pkg::ST_PUSH: begin
               if (rx_s.ready) begin
                  st_r <= kbi_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   assign rx_s.valid = (st_r == kbi_pkg::ST_PUSH);
   assign rx_s.data  = sh_r;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         kb_ack <= 1'b0;
      end else begin
         kb_ack <= ((st_r == kbi_pkg::ST_IDLE) && kb_request) ||
                   (st_r == kbi_pkg::ST_ACK && kb_data);
      end
   end

   // A frame held at a full buffer raises the overrun flag while it waits
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         overrun <= 1'b0;
      end else begin
         overrun <= rx_s.valid && !rx_s.ready;
      end
   end

   //==========================================================
   // Buffer and output
   kbi_fifo #(.WIDTH(`KBI_CODE_BITS), .DEPTH(`KBI_FIFO_DEPTH)) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n_r),
      .wr       (rx_s),
      .rd_valid (fifo_valid),
      .rd_ready (char_ready || !char_valid),
      .rd_data  (fifo_data)
   );

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         char_valid   <= 1'b0;
         char_code    <= 8'h00;
         char_key     <= 7'h00;
         char_pressed <= 1'b0;
      end else if (fifo_valid && (char_ready || !char_valid)) begin
         char_valid   <= 1'b1;
         char_code    <= fifo_data;
         char_key     <= fifo_data[`KBI_KEY_BITS-1:0];
         char_pressed <= fifo_data[`KBI_STATE_BIT];
      end else if (char_ready) begin
         char_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq <= 1'b0;
      end else begin
         irq <= fifo_valid || (char_valid && !char_ready);
      end
   end
endmodule : kbi_top
`default_nettype wire

// ==== tb/kbi_kbd_model.sv ====
// Keyboard side: queue, request line and serial sender
`timescale 1ns/1ps
`default_nettype none
`include "kbi_consts.svh"
module kbi_kbd_model (
   input wire logic clk,
   input wire logic kb_ack,
   output logic kb_request,
   output logic kb_data
);
   // ==========
   // Sender
   logic [7:0] q[$];
   int gap = 0;
   task automatic push(input logic [7:0] c);
      wait (q.size() < 8);
      q.push_back(c);
   endtask : push
   initial begin
      kb_request = 1'b0;
      kb_data = 1'b1;
      forever begin
         @(negedge clk);
         kb_request <= (q.size() != 0);
         if (kb_ack && q.size() != 0) begin
            repeat (gap) @(negedge clk);
            kb_data <= 1'b0;
            repeat (`KBI_BIT_CYCLES) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
               kb_data <= q[0][i];
               repeat (`KBI_BIT_CYCLES) @(negedge clk);
            end
            kb_data <= 1'b1;
            void'(q.pop_front());
            // drop request at once when emptied
            kb_request <= (q.size() != 0);
            repeat (`KBI_BIT_CYCLES) @(negedge clk);
         end
      end
   end
endmodule : kbi_kbd_model
`default_nettype wire

// ==== tb/kbi_top_assertions.sv ====
// Port assertions for the keyboard interface
`timescale 1ns/1ps
`default_nettype none
module kbi_top_assertions (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic kb_request,
   input wire logic kb_data,
   input wire logic kb_ack,
   input wire logic irq,
   input wire logic char_valid,
   input wire logic char_ready,
   input wire logic [7:0] char_code,
   input wire logic [6:0] char_key,
   input wire logic char_pressed,
   input wire logic overrun
);
   // ==========
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_ack_cause; $rose(kb_ack) |-> $past(kb_request); endproperty
   property p_ack_drop; kb_ack && !kb_data |=> !kb_ack; endproperty
   property p_hold;
      char_valid && !char_ready |=> char_valid && $stable(char_code);
   endproperty
   property p_split;
      char_valid |-> char_key == char_code[6:0] && char_pressed == char_code[7];
   endproperty
   property p_irq; char_valid && !char_ready |=> irq; endproperty
   property p_ovr_ack; overrun |-> !kb_ack; endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   a_ack_drop: assert property (p_ack_drop)
      else $error("ack held past start");
   a_hold: assert property (p_hold)
      else $error("char changed before taken");
   a_split: assert property (p_split)
      else $error("key or state field wrong");
   a_irq: assert property (p_irq)
      else $error("no interrupt for char");
   a_ovr_ack: assert property (p_ovr_ack)
      else $error("ack given while buffer full");
   c_take: cover property (char_valid && char_ready);
   c_ack: cover property ($rose(kb_ack));
   c_full: cover property (overrun);
endmodule : kbi_top_assertions
bind kbi_top kbi_top_assertions u_chk (.clk, .reset_n, .kb_request,
   .kb_data, .kb_ack, .irq, .char_valid, .char_ready, .char_code,
   .char_key, .char_pressed, .overrun);
`default_nettype wire

// ==== tb/tb_kbi_top.sv ====
// Self-checking bench for the keyboard interface
`timescale 1ns/1ps
`default_nettype none
`include "kbi_consts.svh"
module tb_kbi_top;
   // ==========
   // Bench
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic char_ready = 1'b0;
   logic go = 1'b0;
   logic rdy;
   logic kb_request, kb_data, kb_ack, irq, char_valid, char_pressed, overrun;
   logic [7:0] char_code, w, c;
   logic [6:0] char_key;
   logic [31:0] lfsr = 32'h82927D5F;
   logic [7:0] edges [4] = '{8'h00, 8'hE7, 8'h67, 8'h80};
   logic [7:0] exp_q[$];
   int num_errors = 0;
   int tests_run = 0;
   always #25 clk = ~clk;
   kbi_top uut (.clk, .reset_n, .kb_request, .kb_data, .kb_ack, .irq,
      .char_valid, .char_ready, .char_code, .char_key, .char_pressed,
      .overrun);
   kbi_kbd_model u_kbd (.clk, .kb_ack, .kb_request, .kb_data);
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : step
   task automatic check(input string n, input logic [7:0] s, e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic conclude();
      if (num_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   always @(negedge clk) begin
      lfsr <= step(lfsr);
      if (go) begin
         rdy = lfsr[0] | lfsr[5];
         char_ready <= rdy;
         // Settled char, taken at the next rising edge
         if (char_valid === 1'b1 && rdy === 1'b1) begin
            w = exp_q.size() ? exp_q.pop_front() : 8'hXX;
            check("code", char_code, w);
            check("key", {1'b0, char_key}, {1'b0, w[6:0]});
            check("pressed", {7'h00, char_pressed}, {7'h00, w[7]});
            check("irq", {7'h00, irq}, 8'h01);
         end
      end
   end
   // Edge codes first, then random; slow and prompt keyboard
   initial begin
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 44; i++) begin
         // key within the matrix, random press flag
         c = (i < 4) ? edges[i] :
             {lfsr[15], 7'(lfsr[14:8] % `KBI_NUM_KEYS)};
         u_kbd.gap = i % 3;
         exp_q.push_back(c);
         u_kbd.push(c);
      end
   end
   // Stalled consumer fills the buffer, then random draining
   initial begin
      wait (reset_n);
      for (int n = 0; n < 15000 && overrun !== 1'b1; n++) @(negedge clk);
      check("overrun", {7'h00, overrun}, 8'h01);
      check("ack", {7'h00, kb_ack}, 8'h00);
      check("irq full", {7'h00, irq}, 8'h01);
      go = 1'b1;
      for (int n = 0; n < 20000 && exp_q.size() != 0; n++) @(negedge clk);
      repeat (20) @(negedge clk);
      check("left", 8'(exp_q.size()), 8'h00);
      check("irq idle", {7'h00, irq}, 8'h00);
      conclude();
   end
   // About 44 frames of 160 cycles plus drain
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      conclude();
   end
endmodule : tb_kbi_top
`default_nettype wire
